/* shared/rrs_pkg.sv */
// Constants and types shared by the reset release and initial state block
`default_nettype none
package rrs_pkg;
  // ==========================================================
  // Vector fetch
  localparam logic [15:0] VEC_LO_ADDR = 16'hfffe;
  localparam logic [15:0] VEC_HI_ADDR = 16'hffff;
  localparam logic [7:0] VEC_BANK = 8'h00;

  // ==========================================================
  // Reset images and defined-bit masks
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [15:0] PAGE_BASE_RESET = 16'h0000;
  localparam logic [9:0] PSW_RESET = 10'h004;
  localparam logic [9:0] PSW_DEF_MASK = 10'h39c;
  localparam int PORT_COUNT = 9;
  localparam logic [PORT_COUNT-1:0] PORT_DIR_LISTED = 9'h1f7;
  localparam logic [7:0] PORT_DIR_RESET = 8'h00;
  localparam logic [5:0] OSC0_RESET = 6'h01;
  localparam logic [7:0] PFC_RESET = 8'h00;
  localparam int TB_COUNT = 3;
  localparam logic [7:0] TB_MODE_RESET = 8'h20;
  localparam int SIO_COUNT = 3;
  localparam logic [7:0] SIO_CTL0_RESET = 8'h08;
  localparam logic [7:0] SIO_CTL1_RESET = 8'h02;
  localparam logic [SIO_COUNT-1:0] SIO_CTL0_LISTED = 3'h3;
  localparam logic [7:0] ADC0_RESET = 8'h00;
  localparam logic [7:0] ADC0_DEF_MASK = 8'hf8;
  localparam logic [4:0] ADC1_RESET = 5'h03;
  localparam int EXTI_COUNT = 3;
  localparam logic [5:0] EXTI_RESET = 6'h00;
  localparam logic [7:0] WAVE_RESET = 8'h00;
  localparam int TA_COUNT = 5;
  localparam logic [7:0] TA_MODE_RESET = 8'h00;
  localparam logic [7:0] PMODE0_RESET = 8'h00;

  // ==========================================================
  // Write selector codes
  localparam logic [5:0] SEL_PROG_BANK = 6'h00;
  localparam logic [5:0] SEL_DATA_BANK = 6'h01;
  localparam logic [5:0] SEL_PAGE_BASE = 6'h02;
  localparam logic [5:0] SEL_PSW = 6'h03;
  localparam logic [5:0] SEL_PDIR_BASE = 6'h04;
  localparam logic [5:0] SEL_OSC0 = 6'h0d;
  localparam logic [5:0] SEL_PFC = 6'h0e;
  localparam logic [5:0] SEL_TB_BASE = 6'h0f;
  localparam logic [5:0] SEL_SIO0_BASE = 6'h12;
  localparam logic [5:0] SEL_SIO1_BASE = 6'h15;
  localparam logic [5:0] SEL_ADC0 = 6'h18;
  localparam logic [5:0] SEL_ADC1 = 6'h19;
  localparam logic [5:0] SEL_EXTI_BASE = 6'h1a;
  localparam logic [5:0] SEL_WAVE = 6'h1d;
  localparam logic [5:0] SEL_TA_BASE = 6'h1e;
  localparam logic [5:0] SEL_PMODE0 = 6'h23;

  // ==========================================================
  // States
  typedef enum logic [1:0] {
    RRS_HOLD = 2'b00,
    RRS_FETCH = 2'b01,
    RRS_RUN = 2'b10
  } rrs_state_t;

  typedef enum logic [1:0] {
    RRS_VF_IDLE = 2'b00,
    RRS_VF_LO = 2'b01,
    RRS_VF_HI = 2'b10
  } rrs_vf_state_t;
endpackage
`default_nettype wire

/* verilog/rrs_release_detect.sv */
// Detects release of the active-low reset pin after it was held low
`default_nettype none
module rrs_release_detect (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reset_pin_n_i,
  output logic in_reset_o,
  output logic release_o
);
  import rrs_pkg::*;

  typedef struct packed {
    logic armed;
    logic in_reset;
    logic release_pulse;
  } rrs_rd_t;

  rrs_rd_t r_reg;
  rrs_rd_t r_next;

  // ==========================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.release_pulse = 1'b0;
    if (!reset_pin_n_i) begin
      r_next.armed = 1'b1;
      r_next.in_reset = 1'b1;
    end else if (r_reg.armed) begin
      // A high pin never seen low does not count as a release
      r_next.armed = 1'b0;
      r_next.in_reset = 1'b0;
      r_next.release_pulse = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      r_reg <= '{armed: 1'b0, in_reset: 1'b1, release_pulse: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign in_reset_o = r_reg.in_reset;
  assign release_o = r_reg.release_pulse;
endmodule
`default_nettype wire

/* verilog/rrs_vector_fetch.sv */
// Reads the two-byte start vector, low byte first
`default_nettype none
module rrs_vector_fetch (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_ack_i,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic [15:0] pc_o,
  output logic done_o
);
  import rrs_pkg::*;

  typedef struct packed {
    rrs_vf_state_t st;
    logic [15:0] addr;
    logic rd;
    logic [15:0] pc;
    logic done;
  } rrs_vf_t;

  rrs_vf_t r_reg;
  rrs_vf_t r_next;

  // ==========================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (abort_i) begin
      r_next.st = RRS_VF_IDLE;
      r_next.rd = 1'b0;
    end else begin
      unique case (r_reg.st)
        RRS_VF_IDLE: begin
          if (start_i) begin
            r_next.st = RRS_VF_LO;
            r_next.addr = VEC_LO_ADDR;
            r_next.rd = 1'b1;
          end
        end
        RRS_VF_LO: begin
          if (mem_ack_i) begin
            r_next.pc[7:0] = mem_rdata_i;
            r_next.st = RRS_VF_HI;
            r_next.addr = VEC_HI_ADDR;
          end
        end
        RRS_VF_HI: begin
          if (mem_ack_i) begin
            r_next.pc[15:8] = mem_rdata_i;
            r_next.st = RRS_VF_IDLE;
            r_next.rd = 1'b0;
            r_next.done = 1'b1;
          end
        end
        default: begin
          r_next.st = RRS_VF_IDLE;
          r_next.rd = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      r_reg <= '{st: RRS_VF_IDLE, addr: 16'h0000, rd: 1'b0, pc: 16'h0000, done: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign mem_addr_o = r_reg.addr;
  assign mem_rd_o = r_reg.rd;
  assign pc_o = r_reg.pc;
  assign done_o = r_reg.done;
endmodule
`default_nettype wire

/* verilog/rrs_reset_init.sv */
// Reset release sequencer and the register set it initialises
// Function
// - Leave reset only when the pin returns high after being held low.
// - Start address is zero bank, high byte from FFFF, low from FFFE.
// - Program bank select forced to zero during reset.
// - Data bank select forced to zero during reset.
// - Direct page base cleared to all zeros during reset.
// - Status word takes its fixed bits; unknown bits keep their value.
// - Listed port direction registers cleared, so those pins are inputs.
// - First oscillator control loads zeros with only bit 0 set.
// - Port function control cleared during reset.
// - Second timer group mode registers load only bit 5 set.
// - Serial second control loads bit 1; listed first controls (0 and 1) load bit 3.
// - Converter control 1 loads two low bits; control 0 clears upper bits.
// - External interrupt controls clear their six bits during reset.
// - Waveform output mode cleared to zero during reset.
// - First timer group mode registers cleared during reset.
// - First processor mode register cleared during reset.
// - Registers without reset values and RAM are left for software.
`default_nettype none
module rrs_reset_init (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reset_pin_n_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_ack_i,
  input wire logic wr_i,
  input wire logic [5:0] wr_sel_i,
  input wire logic [15:0] wr_data_i,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic in_reset_o,
  output logic run_o,
  output logic [23:0] start_addr_o,
  output logic [7:0] program_bank_select_o,
  output logic [7:0] data_bank_select_o,
  output logic [15:0] direct_page_base_o,
  output logic [9:0] processor_status_word_o,
  output logic [rrs_pkg::PORT_COUNT-1:0][7:0] port_dir_o,
  output logic [5:0] osc_ctl0_o,
  output logic [7:0] port_func_ctl_o,
  output logic [rrs_pkg::TB_COUNT-1:0][7:0] timer_b_mode_o,
  output logic [rrs_pkg::SIO_COUNT-1:0][7:0] sio_ctl0_o,
  output logic [rrs_pkg::SIO_COUNT-1:0][7:0] sio_ctl1_o,
  output logic [7:0] adc_ctl0_o,
  output logic [4:0] adc_ctl1_o,
  output logic [rrs_pkg::EXTI_COUNT-1:0][5:0] ext_int_ctl_o,
  output logic [7:0] wave_mode_o,
  output logic [rrs_pkg::TA_COUNT-1:0][7:0] timer_a_mode_o,
  output logic [7:0] proc_mode0_o
);
  import rrs_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    rrs_state_t st;
    logic fetch_go;
    logic run;
    logic [23:0] start_addr;
    logic [7:0] prog_bank;
    logic [7:0] data_bank;
    logic [15:0] page_base;
    logic [9:0] psw;
    logic [PORT_COUNT-1:0][7:0] pdir;
    logic [5:0] osc0;
    logic [7:0] pfc;
    logic [TB_COUNT-1:0][7:0] tb;
    logic [SIO_COUNT-1:0][7:0] sio0;
    logic [SIO_COUNT-1:0][7:0] sio1;
    logic [7:0] adc0;
    logic [4:0] adc1;
    logic [EXTI_COUNT-1:0][5:0] exti;
    logic [7:0] wave;
    logic [TA_COUNT-1:0][7:0] ta;
    logic [7:0] pmode0;
  } rrs_top_t;

  rrs_top_t r_reg;
  rrs_top_t r_next;

  logic pin_in_reset;
  logic pin_release;
  logic [15:0] vec_pc;
  logic vec_done;
  logic pin_hold;
  assign pin_hold = pin_in_reset | ~reset_pin_n_i;

  // ==========================================================
  // Pin release detection
  rrs_release_detect u_detect (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .reset_pin_n_i(reset_pin_n_i),
    .in_reset_o(pin_in_reset),
    .release_o(pin_release)
  );

  // ==========================================================
  // Vector read
  rrs_vector_fetch u_fetch (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(r_reg.fetch_go),
    .abort_i(pin_hold),
    .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i),
    .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o),
    .pc_o(vec_pc),
    .done_o(vec_done)
  );

  // ==========================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.fetch_go = 1'b0;
    if (pin_hold) begin
      // Raw pin too, so a write or fetch on the first low edge is lost
      r_next.st = RRS_HOLD;
      r_next.run = 1'b0;
      r_next.prog_bank = BANK_RESET;
      r_next.data_bank = BANK_RESET;
      r_next.page_base = PAGE_BASE_RESET;
      r_next.psw = (r_reg.psw & ~PSW_DEF_MASK) | (PSW_RESET & PSW_DEF_MASK);
      for (int i = 0; i < PORT_COUNT; i++) begin
        if (PORT_DIR_LISTED[i]) begin
          r_next.pdir[i] = PORT_DIR_RESET;
        end
      end
      r_next.osc0 = OSC0_RESET;
      r_next.pfc = PFC_RESET;
      for (int i = 0; i < TB_COUNT; i++) begin
        r_next.tb[i] = TB_MODE_RESET;
      end
      for (int i = 0; i < SIO_COUNT; i++) begin
        r_next.sio1[i] = SIO_CTL1_RESET;
        if (SIO_CTL0_LISTED[i]) begin
          r_next.sio0[i] = SIO_CTL0_RESET;
        end
      end
      r_next.adc1 = ADC1_RESET;
      r_next.adc0 = (r_reg.adc0 & ~ADC0_DEF_MASK) | (ADC0_RESET & ADC0_DEF_MASK);
      for (int i = 0; i < EXTI_COUNT; i++) begin
        r_next.exti[i] = EXTI_RESET;
      end
      r_next.wave = WAVE_RESET;
      for (int i = 0; i < TA_COUNT; i++) begin
        r_next.ta[i] = TA_MODE_RESET;
      end
      r_next.pmode0 = PMODE0_RESET;
    end else begin
      unique case (r_reg.st)
        RRS_HOLD: begin
          if (pin_release) begin
            r_next.fetch_go = 1'b1;
            r_next.st = RRS_FETCH;
          end
        end
        RRS_FETCH: begin
          if (vec_done) begin
            r_next.start_addr = {VEC_BANK, vec_pc};
            r_next.run = 1'b1;
            r_next.st = RRS_RUN;
          end
        end
        RRS_RUN: begin
          // Unlisted bits are only ever set here, by software
          if (wr_i) begin
            if (wr_sel_i == SEL_PROG_BANK) begin
              r_next.prog_bank = wr_data_i[7:0];
            end
            if (wr_sel_i == SEL_DATA_BANK) begin
              r_next.data_bank = wr_data_i[7:0];
            end
            if (wr_sel_i == SEL_PAGE_BASE) begin
              r_next.page_base = wr_data_i;
            end
            if (wr_sel_i == SEL_PSW) begin
              r_next.psw = wr_data_i[9:0];
            end
            for (int i = 0; i < PORT_COUNT; i++) begin
              if (wr_sel_i == SEL_PDIR_BASE + 6'(i)) begin
                r_next.pdir[i] = wr_data_i[7:0];
              end
            end
            if (wr_sel_i == SEL_OSC0) begin
              r_next.osc0 = wr_data_i[5:0];
            end
            if (wr_sel_i == SEL_PFC) begin
              r_next.pfc = wr_data_i[7:0];
            end
            for (int i = 0; i < TB_COUNT; i++) begin
              if (wr_sel_i == SEL_TB_BASE + 6'(i)) begin
                r_next.tb[i] = wr_data_i[7:0];
              end
            end
            for (int i = 0; i < SIO_COUNT; i++) begin
              if (wr_sel_i == SEL_SIO0_BASE + 6'(i)) begin
                r_next.sio0[i] = wr_data_i[7:0];
              end
              if (wr_sel_i == SEL_SIO1_BASE + 6'(i)) begin
                r_next.sio1[i] = wr_data_i[7:0];
              end
            end
            if (wr_sel_i == SEL_ADC0) begin
              r_next.adc0 = wr_data_i[7:0];
            end
            if (wr_sel_i == SEL_ADC1) begin
              r_next.adc1 = wr_data_i[4:0];
            end
            for (int i = 0; i < EXTI_COUNT; i++) begin
              if (wr_sel_i == SEL_EXTI_BASE + 6'(i)) begin
                r_next.exti[i] = wr_data_i[5:0];
              end
            end
            if (wr_sel_i == SEL_WAVE) begin
              r_next.wave = wr_data_i[7:0];
            end
            for (int i = 0; i < TA_COUNT; i++) begin
              if (wr_sel_i == SEL_TA_BASE + 6'(i)) begin
                r_next.ta[i] = wr_data_i[7:0];
              end
            end
            if (wr_sel_i == SEL_PMODE0) begin
              r_next.pmode0 = wr_data_i[7:0];
            end
          end
        end
        default: begin
          r_next.st = RRS_HOLD;
          r_next.run = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  // System reset clears all, including bits left undefined by the pin reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  assign in_reset_o = pin_in_reset;
  assign run_o = r_reg.run;
  assign start_addr_o = r_reg.start_addr;
  assign program_bank_select_o = r_reg.prog_bank;
  assign data_bank_select_o = r_reg.data_bank;
  assign direct_page_base_o = r_reg.page_base;
  assign processor_status_word_o = r_reg.psw;
  assign port_dir_o = r_reg.pdir;
  assign osc_ctl0_o = r_reg.osc0;
  assign port_func_ctl_o = r_reg.pfc;
  assign timer_b_mode_o = r_reg.tb;
  assign sio_ctl0_o = r_reg.sio0;
  assign sio_ctl1_o = r_reg.sio1;
  assign adc_ctl0_o = r_reg.adc0;
  assign adc_ctl1_o = r_reg.adc1;
  assign ext_int_ctl_o = r_reg.exti;
  assign wave_mode_o = r_reg.wave;
  assign timer_a_mode_o = r_reg.ta;
  assign proc_mode0_o = r_reg.pmode0;
endmodule
`default_nettype wire

/* testbench/rrs_vec_mem.sv */
// Vector memory model answering the start vector reads
`default_nettype none
module rrs_vec_mem #(
  parameter logic [7:0] LO_BYTE = 8'h5e,
  parameter logic [7:0] HI_BYTE = 8'h9c
) (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [3:0] dly_i,
  output logic ack_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Answer after dly_i waiting cycles, one byte per request
  logic ack_reg = 1'b0;
  logic [7:0] data_reg = 8'h00;
  logic [3:0] cnt_reg = 4'h0;
  assign ack_o = ack_reg;
  assign data_o = data_reg;
  always_ff @(posedge clk_i) begin
    if (rd_i && !ack_reg && cnt_reg >= dly_i) begin
      ack_reg <= 1'b1;
      data_reg <= addr_i[0] ? HI_BYTE : LO_BYTE;
      cnt_reg <= 4'h0;
    end else begin
      ack_reg <= 1'b0;
      // Data invalid outside an answer, so it keeps changing
      data_reg <= ~data_reg;
      cnt_reg <= rd_i ? cnt_reg + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

/* testbench/rrs_reset_init_assertions.sv */
// Concurrent checks on the ports of the reset release block
`default_nettype none
module rrs_reset_init_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reset_pin_n_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_ack_i,
  input wire logic wr_i,
  input wire logic [5:0] wr_sel_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic in_reset_o,
  input wire logic run_o,
  input wire logic [23:0] start_addr_o,
  input wire logic [7:0] program_bank_select_o,
  input wire logic [7:0] data_bank_select_o,
  input wire logic [15:0] direct_page_base_o,
  input wire logic [9:0] processor_status_word_o,
  input wire logic [rrs_pkg::PORT_COUNT-1:0][7:0] port_dir_o,
  input wire logic [5:0] osc_ctl0_o,
  input wire logic [7:0] port_func_ctl_o,
  input wire logic [rrs_pkg::TB_COUNT-1:0][7:0] timer_b_mode_o,
  input wire logic [rrs_pkg::SIO_COUNT-1:0][7:0] sio_ctl0_o,
  input wire logic [rrs_pkg::SIO_COUNT-1:0][7:0] sio_ctl1_o,
  input wire logic [7:0] adc_ctl0_o,
  input wire logic [4:0] adc_ctl1_o,
  input wire logic [rrs_pkg::EXTI_COUNT-1:0][5:0] ext_int_ctl_o,
  input wire logic [7:0] wave_mode_o,
  input wire logic [rrs_pkg::TA_COUNT-1:0][7:0] timer_a_mode_o,
  input wire logic [7:0] proc_mode0_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import rrs_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================================
  // Pin hold and vector fetch
  AST_PIN_HOLD: assert property (!reset_pin_n_i |=> in_reset_o && !mem_rd_o)
    else $error("pin low did not hold reset");
  AST_FETCH_START: assert property ($fell(in_reset_o) ##0 reset_pin_n_i [*2] |=>
    mem_rd_o && mem_addr_o == 16'hfffe) else $error("vector read did not start at low byte");
  AST_FETCH_ORDER: assert property (mem_rd_o && mem_ack_i && reset_pin_n_i &&
    mem_addr_o == 16'hfffe |=> mem_rd_o && mem_addr_o == 16'hffff)
    else $error("high vector byte not read second");
  AST_RUN_ADDR: assert property (mem_rd_o && mem_ack_i && reset_pin_n_i &&
    mem_addr_o == 16'hffff ##1 reset_pin_n_i |=> run_o && start_addr_o[23:16] == 8'h00
    && start_addr_o[15:8] == $past(mem_rdata_i, 2)) else $error("start address wrong");
  // ==========================================================
  // Reset images, two cycles into a pin reset, then a software write in run
  AST_BANKS: assert property (!reset_pin_n_i [*2] |=> !run_o &&
    program_bank_select_o == 8'h00 && data_bank_select_o == 8'h00)
    else $error("bank selects not cleared");
  AST_DPR_PSW: assert property (!reset_pin_n_i [*2] |=>
    direct_page_base_o == 16'h0000 && (processor_status_word_o & 10'h39c) == 10'h004)
    else $error("page base or status wrong");
  AST_PORTS: assert property (!reset_pin_n_i [*2] |=>
    (port_dir_o & 72'hffffffffff00ffffff) == 72'h0 && osc_ctl0_o == 6'h01
    && port_func_ctl_o == 8'h00) else $error("port or oscillator image wrong");
  AST_TIMERS: assert property (!reset_pin_n_i [*2] |=>
    timer_b_mode_o == {3{8'h20}} && timer_a_mode_o == 40'h0 && proc_mode0_o == 8'h00)
    else $error("timer or mode image wrong");
  AST_SERIAL: assert property (!reset_pin_n_i [*2] |=>
    sio_ctl1_o == {3{8'h02}} && sio_ctl0_o[1:0] == {8'h08, 8'h08})
    else $error("serial control image wrong");
  AST_ADC_MISC: assert property (!reset_pin_n_i [*2] |=>
    adc_ctl0_o[7:3] == 5'h00 && adc_ctl1_o == 5'h03 && ext_int_ctl_o == 18'h0
    && wave_mode_o == 8'h00) else $error("converter or interrupt image wrong");
  AST_SW_WRITE: assert property (run_o && reset_pin_n_i && wr_i &&
    wr_sel_i == 6'h02 |=> direct_page_base_o == $past(wr_data_i))
    else $error("software write lost");
endmodule
bind rrs_reset_init rrs_reset_init_chk u_chk (.*);
`default_nettype wire

/* testbench/rrs_tb.sv */
// Self-checking testbench for the reset release block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic pin_n = 1'b1;
  logic wr_i = 1'b0;
  logic [5:0] wr_sel_i = 6'h00;
  logic [15:0] wr_data_i = 16'h0000;
  logic [3:0] dly = 4'h0;
  logic [7:0] rdata;
  logic ack, rd, in_reset, run;
  logic [15:0] addr, page_base;
  logic [23:0] start;
  logic [7:0] prog_bank, data_bank, pfc, adc0, wave, pm0;
  logic [9:0] psw;
  logic [8:0][7:0] pdir;
  logic [5:0] osc;
  logic [4:0] adc1;
  logic [2:0][7:0] tbm, sio0, sio1;
  logic [2:0][5:0] exti;
  logic [4:0][7:0] tam;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  rrs_reset_init dut (.clk_i(clk_i), .reset_i(reset_i), .reset_pin_n_i(pin_n),
    .mem_rdata_i(rdata), .mem_ack_i(ack), .wr_i(wr_i), .wr_sel_i(wr_sel_i),
    .wr_data_i(wr_data_i), .mem_addr_o(addr), .mem_rd_o(rd), .in_reset_o(in_reset),
    .run_o(run), .start_addr_o(start), .program_bank_select_o(prog_bank),
    .data_bank_select_o(data_bank), .direct_page_base_o(page_base),
    .processor_status_word_o(psw),
    .port_dir_o(pdir), .osc_ctl0_o(osc), .port_func_ctl_o(pfc), .timer_b_mode_o(tbm),
    .sio_ctl0_o(sio0), .sio_ctl1_o(sio1), .adc_ctl0_o(adc0), .adc_ctl1_o(adc1),
    .ext_int_ctl_o(exti), .wave_mode_o(wave), .timer_a_mode_o(tam), .proc_mode0_o(pm0));
  rrs_vec_mem mem (.clk_i(clk_i), .rd_i(rd), .addr_i(addr), .dly_i(dly), .ack_o(ack),
    .data_o(rdata));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] sel, input logic [15:0] data);
    @(negedge clk_i);
    wr_i = 1'b1;
    wr_sel_i = sel;
    wr_data_i = data;
  endtask
  // Pin reset with a write that must be lost, image check, then start-up
  task automatic start_up(input logic [9:0] psw_exp, input logic [7:0] u8);
    @(negedge clk_i);
    pin_n = 1'b0;
    wr_i = 1'b1;
    wr_sel_i = 6'h00;
    wr_data_i = 16'hffff;
    @(negedge clk_i);
    wr_i = 1'b0;
    chk({in_reset, run, prog_bank}, {2'b10, 8'h00});
    repeat (2) @(negedge clk_i);
    chk({in_reset, run, rd}, 3'b100);
    chk({prog_bank, data_bank}, 16'h0000);
    chk(page_base, 16'h0000);
    chk(psw, psw_exp);
    chk(pdir, {40'h0, u8, 24'h0});
    chk({osc, pfc}, {6'h01, 8'h00});
    chk(tbm, {3{8'h20}});
    chk({sio1, sio0}, {{3{8'h02}}, u8, 16'h0808});
    chk({adc0, adc1}, {5'h00, u8[2:0], 5'h03});
    chk(exti, 18'h0);
    chk({wave, tam, pm0}, 56'h0);
    pin_n = 1'b1;
    for (int i = 0; i < 60 && run !== 1'b1; i++) @(negedge clk_i);
    chk({run, rd, start}, {2'b10, 24'h009c5e});
    chk(prog_bank, 8'h00);
  endtask
  // ==========================================================
  // Watchdog on the whole run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (10) @(negedge clk_i);
    chk({in_reset, run, rd}, 3'b100);
    $display("test idle pin done");
    start_up(10'h004, 8'h00);
    $display("test first start-up done");
    for (int s = 0; s < 36; s++) wr(s[5:0], 16'ha5c3);
    wr(6'h3f, 16'h0000);
    @(negedge clk_i);
    wr_i = 1'b0;
    chk({prog_bank, data_bank, page_base, psw}, {16'hc3c3, 16'ha5c3, 10'h1c3});
    chk({exti, pdir[3], pm0}, {{3{6'h03}}, 16'hc3c3});
    // Undefined bits keep software values through a pin reset
    start_up(10'h047, 8'hc3);
    $display("test writes and second reset done");
    dly = 4'h3;
    @(negedge clk_i);
    pin_n = 1'b0;
    repeat (2) @(negedge clk_i);
    pin_n = 1'b1;
    for (int i = 0; i < 40 && ack !== 1'b1; i++) @(negedge clk_i);
    chk({rd, addr}, {1'b1, 16'hfffe});
    start_up(10'h047, 8'hc3);
    $display("test abort and slow vector done");
    report_and_stop();
  end
endmodule
`default_nettype wire
